// ### logic/bfs_consts.vh
// Constants for the ballast fault supervisor: timing counts and phase codes.
// Assumes a 20 MHz core clock; all comparator flags are active high.
`ifndef BFS_CONSTS_VH
`define BFS_CONSTS_VH
`define BFS_CLK_MHZ       20
`define BFS_NS(t)         (((t) * `BFS_CLK_MHZ + 999) / 1000)
`define BFS_T_260NS       260
`define BFS_T_250NS       250
`define BFS_T_400NS       400
`define BFS_T_1US         1000
`define BFS_T_5US         5000
`define BFS_T_10US        10000
`define BFS_T_40US        40000
`define BFS_T_80US        80000
`define BFS_T_4MS         4000000
`define BFS_C_260NS       `BFS_NS(`BFS_T_260NS)
`define BFS_C_250NS       `BFS_NS(`BFS_T_250NS)
`define BFS_C_400NS       `BFS_NS(`BFS_T_400NS)
`define BFS_C_1US         `BFS_NS(`BFS_T_1US)
`define BFS_C_5US         `BFS_NS(`BFS_T_5US)
`define BFS_C_10US        `BFS_NS(`BFS_T_10US)
`define BFS_C_40US        `BFS_NS(`BFS_T_40US)
`define BFS_C_80US        `BFS_NS(`BFS_T_80US)
`define BFS_C_4MS         `BFS_NS(`BFS_T_4MS)
`define BFS_MS_SOFT       10
`define BFS_MS_PREHEAT    2000
`define BFS_MS_IGNITE     235
`define BFS_MS_PRERUN     250
`define BFS_MS_SLOW       500
`define BFS_MS_OPEN       1
`define BFS_T_610US       610
`define BFS_US_TICK       40
`define BFS_PH_OFF        3'h0
`define BFS_PH_SOFT       3'h1
`define BFS_PH_PREHEAT    3'h2
`define BFS_PH_IGNITE     3'h3
`define BFS_PH_PRERUN     3'h4
`define BFS_PH_RUN        3'h5
`define BFS_PH_FAULT      3'h6
`define BFS_SLOW_N        5
`endif

// ### logic/bfs_supervisor.v
// Ballast fault supervisor: phase sequencer, persistence filters, actions.
// Assumes comparator flags asynchronous to CORE_CLK_IN; sequencer inputs from inverter control.
`timescale 1ns/1ns
`include "bfs_consts.vh"
module bfs_supervisor #(
    parameter [31:0] TICK_4MS    = `BFS_C_4MS,
    parameter [31:0] TICK_40US   = `BFS_C_40US,
    parameter [31:0] C_10US      = `BFS_C_10US,
    parameter [31:0] C_80US      = `BFS_C_80US,
    parameter [11:0] PREHEAT_MS  = 12'h000
) (
    input  wire CORE_CLK_IN,
    input  wire RST_B_IN,
    input  wire LAMP_PEAK_FAULT_IN,
    input  wire LAMP_ASYMMETRY_FAULT_IN,
    input  wire CAP_LOAD_MILD_IN,
    input  wire CAP_LOAD_SEVERE_IN,
    input  wire FILAMENT_OPEN_IN,
    input  wire FILAMENT_LOW_SIDE_OPEN_IN,
    input  wire LAMP_SENSE_INPUT_A_LOW_IN,
    input  wire LAMP_SENSE_INPUT_B_LOW_IN,
    input  wire BUS_OVER_109_IN,
    input  wire BUS_OVER_105_IN,
    input  wire BUS_UNDER_75_IN,
    input  wire BUS_UNDER_15_IN,
    input  wire PFC_CURRENT_SENSE_IN,
    input  wire INVERTER_CURRENT_LIMIT_IN,
    input  wire INVERTER_CURRENT_SENSE_IN,
    input  wire SUPPLY_BELOW_START_IN,
    input  wire SUPPLY_LOCKOUT_THRESHOLD_IN,
    input  wire RUN_FREQ_REACHED_IN,
    input  wire LAMP_RETURN_IN,
    output reg  POWER_ON_OUT,
    output reg  FAULT_LATCHED_OUT,
    output reg  PFC_OFF_OUT,
    output reg  FREQ_UP_OUT,
    output reg  POWER_UP_BLOCKED_OUT,
    output reg  [2:0] PHASE_OUT
);

    // ****************************************
    // Input synchroniser
    // ****************************************
    localparam NF = 17;
    wire [NF-1:0] raw = {LAMP_PEAK_FAULT_IN, LAMP_ASYMMETRY_FAULT_IN, CAP_LOAD_MILD_IN,
                         CAP_LOAD_SEVERE_IN, FILAMENT_OPEN_IN, FILAMENT_LOW_SIDE_OPEN_IN,
                         LAMP_SENSE_INPUT_A_LOW_IN | LAMP_SENSE_INPUT_B_LOW_IN, BUS_OVER_109_IN,
                         BUS_OVER_105_IN, BUS_UNDER_75_IN, BUS_UNDER_15_IN, PFC_CURRENT_SENSE_IN,
                         INVERTER_CURRENT_LIMIT_IN, INVERTER_CURRENT_SENSE_IN,
                         SUPPLY_BELOW_START_IN, SUPPLY_LOCKOUT_THRESHOLD_IN, LAMP_RETURN_IN};
    reg  [NF-1:0] s1_q;
    reg  [NF-1:0] s2_q;
    always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            s1_q <= {NF{1'b0}};
            s2_q <= {NF{1'b0}};
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    wire f_peak  = s2_q[16];
    wire f_asym  = s2_q[15];
    wire f_cap1  = s2_q[14];
    wire f_cap2  = s2_q[13];
    wire f_fil   = s2_q[12];
    wire f_lsfil = s2_q[11];
    wire f_hsfil = s2_q[10];
    wire f_ov    = s2_q[9];
    wire f_ov105 = s2_q[8];
    wire f_uv    = s2_q[7];
    wire f_ol    = s2_q[6];
    wire f_pfcoc = s2_q[5];
    wire f_ilim  = s2_q[4];
    wire f_ioc   = s2_q[3];
    wire f_start = s2_q[2];
    wire f_supply_lockout_threshold  = s2_q[1];
    wire f_ret   = s2_q[0];

    // ****************************************
    // Timebase
    // ****************************************
    reg  [31:0] t4_q;
    reg  [31:0] t40_q;
    wire        tick4   = (t4_q == TICK_4MS - 32'h1);
    wire        tick40  = (t40_q == TICK_40US - 32'h1);
    always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            t4_q  <= 32'h0;
            t40_q <= 32'h0;
        end else begin
            t4_q  <= tick4 ? 32'h0 : t4_q + 32'h1;
            t40_q <= tick40 ? 32'h0 : t40_q + 32'h1;
        end
    end

    // Persistence of a level for n cycles
    function [31:0] bfs_run;
        input        f;
        input [31:0] c;
        input [31:0] n;
        begin
            bfs_run = !f ? 32'h0 : ((c < n) ? c + 32'h1 : c);
        end
    endfunction

    // Up/down integrator step
    function [15:0] bfs_ud;
        input        f;
        input        tk;
        input [15:0] c;
        begin
            bfs_ud = !tk ? c : (f ? c + 16'h1 : ((c != 16'h0) ? c - 16'h1 : c));
        end
    endfunction

    // ****************************************
    // Fast persistence counters
    // ****************************************
    reg  [31:0] c_pfc_q;
    reg  [31:0] c_ilim_q;
    reg  [31:0] c_ioc_q;
    reg  [31:0] c_ol_q;
    reg  [31:0] c_start_q;
    reg  [31:0] c_supply_lockout_threshold_q;
    reg  [31:0] c_ovp_q;
    reg  [31:0] c_uv_q;
    reg  [31:0] c_up_q;
    reg  [31:0] c_ls_q;
    reg  [31:0] c_hs_q;
    reg  [31:0] c_ovr_q;
    wire p_pfc   = (c_pfc_q   >= `BFS_C_260NS);
    wire p_ilim  = (c_ilim_q  >= `BFS_C_250NS);
    wire p_ioc   = (c_ioc_q   >= `BFS_C_400NS);
    wire p_ol    = (c_ol_q    >= `BFS_C_1US);
    wire p_start = (c_start_q >= `BFS_C_1US);
    wire p_supply_lockout_threshold  = (c_supply_lockout_threshold_q  >= `BFS_C_1US);
    wire p_ovp   = (c_ovp_q   >= `BFS_C_5US);
    wire p_uv    = (c_uv_q    >= C_80US);
    wire p_ovr   = (c_ovr_q   >= C_10US);
    // Open filament must stand a full millisecond of cycles
    wire p_ls    = (c_ls_q    >= (TICK_4MS >> 2));
    wire p_hs    = (c_hs_q    >= (TICK_4MS >> 2));
    reg  [2:0]  ph_q;
    wire        active = (ph_q != `BFS_PH_OFF) && (ph_q != `BFS_PH_FAULT);
    wire        run    = (ph_q == `BFS_PH_RUN);
    always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            c_pfc_q   <= 32'h0;
            c_ilim_q  <= 32'h0;
            c_ioc_q   <= 32'h0;
            c_ol_q    <= 32'h0;
            c_start_q <= 32'h0;
            c_supply_lockout_threshold_q  <= 32'h0;
            c_ovp_q   <= 32'h0;
            c_uv_q    <= 32'h0;
            c_up_q    <= 32'h0;
            c_ls_q    <= 32'h0;
            c_hs_q    <= 32'h0;
            c_ovr_q   <= 32'h0;
        end else begin
            c_pfc_q   <= bfs_run(f_pfcoc, c_pfc_q, `BFS_C_260NS);
            c_ilim_q  <= bfs_run(f_ilim, c_ilim_q, `BFS_C_250NS);
            c_ioc_q   <= bfs_run(f_ioc, c_ioc_q, `BFS_C_400NS);
            c_ol_q    <= bfs_run(f_ol, c_ol_q, `BFS_C_1US);
            c_start_q <= bfs_run(f_start, c_start_q, `BFS_C_1US);
            c_supply_lockout_threshold_q  <= bfs_run(f_supply_lockout_threshold, c_supply_lockout_threshold_q, `BFS_C_1US);
            c_ovp_q   <= bfs_run(f_ov, c_ovp_q, `BFS_C_5US);
            c_uv_q    <= bfs_run(f_uv & run, c_uv_q, C_80US);
            c_up_q    <= active ? bfs_run(1'b1, c_up_q, C_10US) : 32'h0;
            c_ovr_q   <= bfs_run(f_ov & (c_up_q >= C_10US) & !run, c_ovr_q, C_10US);
            c_ls_q    <= bfs_run(f_lsfil, c_ls_q, TICK_4MS >> 2);
            c_hs_q    <= bfs_run(f_hsfil, c_hs_q, TICK_4MS >> 2);
        end
    end

    // ****************************************
    // Slow integrators
    // ****************************************
    localparam [15:0] SLOW_LIM = `BFS_MS_SLOW / 4;
    localparam [15:0] CAP2_LIM = (`BFS_T_610US + `BFS_US_TICK - 1) / `BFS_US_TICK;
    reg  [15:0] i_asym_q;
    reg  [15:0] i_cap1_q;
    reg  [15:0] i_fil_q;
    reg  [15:0] i_ov_q;
    reg  [15:0] i_cap2_q;
    reg  [15:0] i_peak_q;
    wire cap2_en = run || (ph_q == `BFS_PH_PREHEAT);
    always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            i_asym_q <= 16'h0;
            i_cap1_q <= 16'h0;
            i_fil_q  <= 16'h0;
            i_ov_q   <= 16'h0;
            i_cap2_q <= 16'h0;
            i_peak_q <= 16'h0;
        end else begin
            i_asym_q <= run ? bfs_ud(f_asym, tick4, i_asym_q) : 16'h0;
            i_cap1_q <= run ? bfs_ud(f_cap1, tick4, i_cap1_q) : 16'h0;
            i_fil_q  <= run ? bfs_ud(f_fil, tick4, i_fil_q) : 16'h0;
            i_ov_q   <= run ? bfs_ud(f_ov, tick4, i_ov_q) : 16'h0;
            i_cap2_q <= cap2_en ? bfs_ud(f_cap2, tick40, i_cap2_q) : 16'h0;
            i_peak_q <= run ? bfs_ud(f_peak, tick40, i_peak_q) : 16'h0;
        end
    end
    wire t_latch = (run && (i_peak_q >= CAP2_LIM || i_asym_q >= SLOW_LIM || i_cap1_q >= SLOW_LIM
                   || i_fil_q >= SLOW_LIM || i_ov_q >= SLOW_LIM))
                   || (cap2_en && i_cap2_q >= CAP2_LIM) || (active && p_ioc);
    wire t_soft  = active && (p_ol || p_uv || p_ovr);

    // ****************************************
    // Phase sequencer
    // ****************************************
    reg  [15:0] ms_q;
    reg  [31:0] msd_q;
    wire        ms_tick = (msd_q == (TICK_4MS >> 2) - 32'h1);
    reg  [2:0]  ph_d;
    reg         latch_q;
    wire        block = p_start | p_ls | p_hs;
    always @* begin
        ph_d = ph_q;
        case (ph_q)
            `BFS_PH_OFF:     if (!block && !latch_q) ph_d = `BFS_PH_SOFT;
            `BFS_PH_SOFT:    if (ms_tick && ms_q >= `BFS_MS_SOFT - 1) ph_d = `BFS_PH_PREHEAT;
            `BFS_PH_PREHEAT: if (ms_tick && ms_q >= PREHEAT_MS) ph_d = `BFS_PH_IGNITE;
            `BFS_PH_IGNITE:  if (RUN_FREQ_REACHED_IN) ph_d = `BFS_PH_PRERUN;
            `BFS_PH_PRERUN:  if (ms_tick && ms_q >= `BFS_MS_PRERUN - 1) ph_d = `BFS_PH_RUN;
            `BFS_PH_RUN:     ph_d = `BFS_PH_RUN;
            `BFS_PH_FAULT:   ph_d = `BFS_PH_FAULT;
            default:         ph_d = `BFS_PH_OFF;
        endcase
        if (ph_q == `BFS_PH_IGNITE && ms_tick && ms_q >= `BFS_MS_IGNITE - 1 && !RUN_FREQ_REACHED_IN)
            ph_d = `BFS_PH_FAULT;
        if (t_soft)
            ph_d = `BFS_PH_OFF;
        if (t_latch)
            ph_d = `BFS_PH_FAULT;
        if (ph_q == `BFS_PH_FAULT && f_ret)
            ph_d = `BFS_PH_OFF;
        if (p_supply_lockout_threshold)
            ph_d = `BFS_PH_OFF;
    end
    always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ph_q    <= `BFS_PH_OFF;
            ms_q    <= 16'h0;
            msd_q   <= 32'h0;
            latch_q <= 1'b0;
        end else begin
            ph_q    <= ph_d;
            msd_q   <= (ph_d != ph_q || ms_tick) ? 32'h0 : msd_q + 32'h1;
            ms_q    <= (ph_d != ph_q) ? 16'h0 : (ms_tick ? ms_q + 16'h1 : ms_q);
            latch_q <= (ph_d == `BFS_PH_FAULT);
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    reg ovp_hold_q;
    always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ovp_hold_q           <= 1'b0;
            POWER_ON_OUT         <= 1'b0;
            FAULT_LATCHED_OUT    <= 1'b0;
            PFC_OFF_OUT          <= 1'b1;
            FREQ_UP_OUT          <= 1'b0;
            POWER_UP_BLOCKED_OUT <= 1'b0;
            PHASE_OUT            <= `BFS_PH_OFF;
        end else begin
            ovp_hold_q           <= p_ovp | (ovp_hold_q & f_ov105);
            POWER_ON_OUT         <= (ph_d != `BFS_PH_OFF) && (ph_d != `BFS_PH_FAULT);
            FAULT_LATCHED_OUT    <= (ph_d == `BFS_PH_FAULT);
            PFC_OFF_OUT          <= p_pfc | p_ovp | ovp_hold_q | !((ph_d != `BFS_PH_OFF)
                                    && (ph_d != `BFS_PH_FAULT));
            FREQ_UP_OUT          <= p_ilim && (ph_q == `BFS_PH_IGNITE) && !t_latch;
            POWER_UP_BLOCKED_OUT <= block;
            PHASE_OUT            <= ph_d;
        end
    end

endmodule

// ### tb/bfs_far_side.sv
// Far-side model: inverter phase sequencer answer for ignition.
// Assumes the supervisor's phase code and the shared core clock.
`timescale 1ns/1ns
module bfs_far_side #(
    parameter integer DELAY = 300
) (
    input  wire       clk_in,
    input  wire       rst_b_in,
    input  wire [2:0] phase_in,
    output reg        run_freq_reached_out
);
    // ****************************************
    // Run frequency reached after a delay
    // ****************************************
    reg [15:0] cnt_q;
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= 16'h0000;
            run_freq_reached_out <= 1'b0;
        end else begin
            cnt_q <= (phase_in == 3'h3) ? cnt_q + 16'h0001 : 16'h0000;
            run_freq_reached_out <= (phase_in == 3'h3) && (cnt_q >= DELAY);
        end
    end
endmodule

// ### tb/bfs_checker.sv
// Checker of the fault supervisor's port behaviour.
// Assumes attachment by bind to bfs_supervisor.
`timescale 1ns/1ns
module bfs_checker #(
    parameter [31:0] TICK_4MS = 32'd400
) (
    input wire       CORE_CLK_IN,
    input wire       RST_B_IN,
    input wire       INVERTER_CURRENT_SENSE_IN,
    input wire       PFC_CURRENT_SENSE_IN,
    input wire       SUPPLY_LOCKOUT_THRESHOLD_IN,
    input wire       LAMP_RETURN_IN,
    input wire       POWER_ON_OUT,
    input wire       FAULT_LATCHED_OUT,
    input wire       PFC_OFF_OUT,
    input wire       FREQ_UP_OUT,
    input wire       POWER_UP_BLOCKED_OUT,
    input wire [2:0] PHASE_OUT
);
    // ****************************************
    // Helper counters and assertions
    // ****************************************
    localparam int MS = TICK_4MS / 4;
    reg [5:0]  lock_q;
    reg [7:0]  age_q;
    reg [2:0]  ph_q;
    reg [15:0] cnt_q;
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            lock_q <= 6'h00;
            age_q <= 8'hff;
            ph_q <= 3'h0;
            cnt_q <= 16'h0000;
        end else begin
            lock_q <= !SUPPLY_LOCKOUT_THRESHOLD_IN ? 6'h00 : (lock_q == 6'h3f ? lock_q : lock_q + 6'h01);
            age_q <= (LAMP_RETURN_IN || SUPPLY_LOCKOUT_THRESHOLD_IN) ? 8'h00 : (age_q == 8'hff ? age_q : age_q + 8'h01);
            ph_q <= PHASE_OUT;
            cnt_q <= (PHASE_OUT != ph_q) ? 16'h0001 : cnt_q + 16'h0001;
        end
    end
    a_inv_oc_latch: assert property ((INVERTER_CURRENT_SENSE_IN && POWER_ON_OUT)[*8] |-> ##[1:6] FAULT_LATCHED_OUT)
        else $error("inverter overcurrent did not latch");
    a_pfc_oc_off: assert property (PFC_CURRENT_SENSE_IN[*6] |-> ##[1:6] PFC_OFF_OUT)
        else $error("pfc overcurrent did not switch pfc off");
    a_lockout_clears: assert property (lock_q == 6'd24 |-> !FAULT_LATCHED_OUT && !POWER_ON_OUT)
        else $error("lockout did not power down and clear");
    a_latch_holds: assert property ($fell(FAULT_LATCHED_OUT) |-> age_q < 8'd40)
        else $error("latched fault dropped without cause");
    a_fault_power_off: assert property (FAULT_LATCHED_OUT |-> !POWER_ON_OUT && PHASE_OUT == 3'h6)
        else $error("power on while fault latched");
    a_phase_order: assert property (PHASE_OUT != ph_q |-> PHASE_OUT == 3'h0 || PHASE_OUT == 3'h6
        || PHASE_OUT == ph_q + 3'h1 || (ph_q == 3'h1 && PHASE_OUT == 3'h3) || (ph_q == 3'h6 && PHASE_OUT == 3'h1))
        else $error("illegal phase step");
    a_phase_time: assert property ((ph_q == 3'h1 && (PHASE_OUT == 3'h2 || PHASE_OUT == 3'h3)) |->
        cnt_q >= 9 * MS && cnt_q <= 10 * MS + 10)
        else $error("softstart length wrong");
    a_prerun_time: assert property ((ph_q == 3'h4 && PHASE_OUT == 3'h5) |->
        cnt_q >= 249 * MS && cnt_q <= 250 * MS + 10)
        else $error("prerun length wrong");
    a_blocked_off: assert property (POWER_UP_BLOCKED_OUT && $past(POWER_UP_BLOCKED_OUT) && ph_q == 3'h0 |->
        PHASE_OUT == 3'h0)
        else $error("power up while blocked");
    a_freq_up_ignite: assert property (FREQ_UP_OUT |-> PHASE_OUT == 3'h3 || ph_q == 3'h3)
        else $error("frequency raise outside ignition");
endmodule
bind bfs_supervisor bfs_checker #(.TICK_4MS(TICK_4MS)) bfs_checker_inst (.CORE_CLK_IN(CORE_CLK_IN),
    .RST_B_IN(RST_B_IN), .INVERTER_CURRENT_SENSE_IN(INVERTER_CURRENT_SENSE_IN),
    .PFC_CURRENT_SENSE_IN(PFC_CURRENT_SENSE_IN), .SUPPLY_LOCKOUT_THRESHOLD_IN(SUPPLY_LOCKOUT_THRESHOLD_IN),
    .LAMP_RETURN_IN(LAMP_RETURN_IN), .POWER_ON_OUT(POWER_ON_OUT), .FAULT_LATCHED_OUT(FAULT_LATCHED_OUT),
    .PFC_OFF_OUT(PFC_OFF_OUT), .FREQ_UP_OUT(FREQ_UP_OUT), .POWER_UP_BLOCKED_OUT(POWER_UP_BLOCKED_OUT),
    .PHASE_OUT(PHASE_OUT));

// ### tb/ballast_fault_supervisor_tb.sv
// Self-checking bench of the fault supervisor with random hold times.
// Assumes shortened timebase parameters; flags are driven as a vector.
`timescale 1ns/1ns
module ballast_fault_supervisor_tb;
    // ****************************************
    // Stimulus, checks and verdict
    // ****************************************
    localparam integer TICK = 400;
    reg        clk = 1'b0;
    reg        rst_b = 1'b0;
    reg [17:0] f = 18'h00000;
    wire       run_ok;
    wire       pwr, flt, pfc_off, fup, blk;
    wire [2:0] ph;
    integer    n_errors = 0;
    integer    cmp_count = 0;
    integer    i;
    integer    blk_idx [0:3];
    always #25 clk = ~clk;
    bfs_supervisor #(.TICK_4MS(TICK), .TICK_40US(8), .C_10US(200), .C_80US(1600), .PREHEAT_MS(12'h000))
    bfs_supervisor_inst (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .LAMP_PEAK_FAULT_IN(f[0]),
        .LAMP_ASYMMETRY_FAULT_IN(f[1]), .CAP_LOAD_MILD_IN(f[2]), .CAP_LOAD_SEVERE_IN(f[3]),
        .FILAMENT_OPEN_IN(f[4]), .FILAMENT_LOW_SIDE_OPEN_IN(f[5]), .LAMP_SENSE_INPUT_A_LOW_IN(f[6]),
        .LAMP_SENSE_INPUT_B_LOW_IN(f[7]), .BUS_OVER_109_IN(f[8]), .BUS_OVER_105_IN(f[9]),
        .BUS_UNDER_75_IN(f[10]), .BUS_UNDER_15_IN(f[11]), .PFC_CURRENT_SENSE_IN(f[12]),
        .INVERTER_CURRENT_LIMIT_IN(f[13]), .INVERTER_CURRENT_SENSE_IN(f[14]), .SUPPLY_BELOW_START_IN(f[15]),
        .SUPPLY_LOCKOUT_THRESHOLD_IN(f[16]), .RUN_FREQ_REACHED_IN(run_ok), .LAMP_RETURN_IN(f[17]),
        .POWER_ON_OUT(pwr), .FAULT_LATCHED_OUT(flt), .PFC_OFF_OUT(pfc_off), .FREQ_UP_OUT(fup),
        .POWER_UP_BLOCKED_OUT(blk), .PHASE_OUT(ph));
    bfs_far_side #(.DELAY(300)) bfs_far_side_inst (.clk_in(clk), .rst_b_in(rst_b), .phase_in(ph),
        .run_freq_reached_out(run_ok));
    function integer ms_cyc(input integer ms);
        ms_cyc = ms * TICK / 4;
    endfunction
    task cyc(input integer n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task hold(input integer b, input integer n);
        f[b] = 1'b1;
        cyc(n);
        f[b] = 1'b0;
    endtask
    task wait_ph(input [2:0] p);
        i = 0;
        while (ph !== p && i < 40000) begin
            cyc(1);
            i = i + 1;
        end
        chk({5'h00, ph}, {5'h00, p});
    endtask
    task report_and_stop;
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(60000 * 50);
        n_errors = n_errors + 1;
        report_and_stop;
    end
    initial begin
        i = $urandom(32'h140e7597);
        blk_idx[0] = 5;
        blk_idx[1] = 6;
        blk_idx[2] = 7;
        blk_idx[3] = 15;
        cyc(3);
        chk({pwr, flt, pfc_off, fup, blk, ph}, 8'h20);
        rst_b = 1'b1;
        cyc(2);
        chk({5'h00, ph}, 8'h01);
        f[3] = 1'b1;
        hold(0, 300 + $urandom % 100);
        f[3] = 1'b0;
        cyc(3);
        chk({7'h00, flt}, 8'h00);
        hold(14, 14 + $urandom % 10);
        cyc(3);
        chk({flt, pwr, 3'h0, ph}, 8'h86);
        hold(17, 10);
        cyc(20);
        chk({7'h00, flt}, 8'h00);
        hold(12, 10 + $urandom % 5);
        cyc(2);
        chk({7'h00, pfc_off}, 8'h01);
        cyc(5);
        chk({7'h00, pfc_off}, 8'h00);
        hold(14, 14 + $urandom % 10);
        for (int k = 0; k < 4; k++) begin
            f[blk_idx[k]] = 1'b1;
            f[16] = 1'b1;
            cyc(3 * ms_cyc(1));
            chk({flt, pwr, 3'h0, ph}, 8'h00);
            f[16] = 1'b0;
            cyc(50);
            chk({blk, 4'h0, ph}, 8'h80);
            f[blk_idx[k]] = 1'b0;
            cyc(3 * ms_cyc(1));
            chk({5'h00, ph}, 8'h01);
        end
        f[11] = 1'b1;
        cyc(25);
        chk({flt, pwr, 3'h0, ph}, 8'h00);
        f[11] = 1'b0;
        wait_ph(3'h3);
        hold(13, 10);
        cyc(2);
        chk({7'h00, fup}, 8'h01);
        wait_ph(3'h5);
        f[8] = 1'b1;
        f[9] = 1'b1;
        cyc(120);
        f[8] = 1'b0;
        cyc(50);
        chk({7'h00, pfc_off}, 8'h01);
        f[9] = 1'b0;
        cyc(10);
        chk({7'h00, pfc_off}, 8'h00);
        hold(0, 200 + $urandom % 50);
        cyc(3);
        chk({flt, pwr, 3'h0, ph}, 8'h86);
        report_and_stop;
    end
endmodule
